/* File: verilog/spt_core.v */
// serial port transmit and receive datapath
`timescale 1ns/1ps
`include "spt_regs.vh"
module spt_core #(
	parameter [15:0] BAUD_DIV = `SPT_BAUD_DIV_RST
) (
	input wire ref_clk,
	input wire rst_n,
	input wire ce,
	input wire [2:0] char_size_sel,
	input wire parity_enable_bit,
	input wire parity_odd,
	input wire two_stop,
	input wire sync_mode,
	input wire clk_pol,
	input wire tx_enable_bit,
	input wire rx_enable_bit,
	input wire tx_buf_empty_irq_en,
	input wire tx_done_irq_en,
	input wire tx_ninth_bit,
	input wire data_wr,
	input wire [7:0] data_wdata,
	input wire data_rd,
	input wire tx_done_clr,
	input wire tx_done_irq_ack,
	input wire rxd_pin,
	input wire ext_serial_clock_pin,
	output reg txd_out,
	output reg txd_oe,
	output reg rxd_owned,
	output reg [7:0] rx_data,
	output reg rx_ninth_bit,
	output reg frame_err_flag,
	output reg overrun_flag,
	output reg parity_err_flag,
	output reg rx_avail_flag,
	output reg tx_buf_empty_flag,
	output reg tx_done_flag,
	output reg tx_buf_empty_irq,
	output reg tx_done_irq
);
	localparam ST_IDLE = 3'b001;
	localparam ST_SHIFT = 3'b010;
	localparam ST_DONE = 3'b100;

	// data bits per character: code 0..3 -> 5..8, code 7 -> 9
	function [3:0] nbits;
		input [2:0] c;
		begin
			nbits = (c == `SPT_CSZ_9) ? 4'd9 : ({2'b00, c[1:0]} + 4'd5);
		end
	endfunction

	// pin synchronisers, the first stage is read by the second only
	reg rxd_s1_r, rxd_s2_r, xck_s1_r, xck_s2_r, xck_d_r;
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			rxd_s1_r <= 1'b1;
			rxd_s2_r <= 1'b1;
			xck_s1_r <= 1'b0;
			xck_s2_r <= 1'b0;
			xck_d_r <= 1'b0;
		end else if (ce) begin
			rxd_s1_r <= rxd_pin;
			rxd_s2_r <= rxd_s1_r;
			xck_s1_r <= ext_serial_clock_pin;
			xck_s2_r <= xck_s1_r;
			xck_d_r <= xck_s2_r;
		end
	end
	wire xck_rise = xck_s2_r & ~xck_d_r;
	wire xck_fall = ~xck_s2_r & xck_d_r;
	wire sync_change = clk_pol ? xck_fall : xck_rise;
	wire sync_sample = clk_pol ? xck_rise : xck_fall;

	// oversample tick at sixteen times the baud rate
	reg [15:0] div_r;
	wire os_tick = (div_r == 16'h0000);
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			div_r <= 16'h0000;
		end else if (ce) begin
			div_r <= os_tick ? BAUD_DIV : div_r - 16'h0001;
		end
	end

	// transmit bit tick: every sixteenth oversample or external clock edge
	reg [3:0] tx_os_r;
	wire tx_tick = sync_mode ? sync_change : (os_tick && tx_os_r == 4'hf);
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_os_r <= 4'h0;
		end else if (ce && os_tick) begin
			tx_os_r <= tx_os_r + 4'h1;
		end
	end

	// transmit buffer and shifter
	reg [8:0] tx_buf_r;
	reg [2:0] tx_st_r;
	reg [11:0] tx_sh_r;
	reg [3:0] tx_cnt_r;
	reg tx_active_r;
	wire [3:0] tn = nbits(char_size_sel);
	wire [8:0] tmask = (9'h1ff >> (4'd9 - tn));
	wire [8:0] tdata = tx_buf_r & tmask;
	wire tpar = (^tdata) ^ parity_odd;
	// a waiting char is taken when idle or right at the end of the last stop bit
	wire tx_end = tx_st_r[1] && tx_cnt_r == 4'd1;
	wire tx_take = tx_tick && !tx_buf_empty_flag && (tx_st_r[0] || tx_end);
	// lsb-aligned frame: data, optional parity, then ones for the stop bits
	wire [11:0] tones = 12'hfff << tn;
	wire [11:0] tpbit = {11'h000, tpar} << tn;
	wire [11:0] tfr_par = (tones << 1) | tpbit | {3'b000, tdata};
	wire [11:0] tfr_nopar = tones | {3'b000, tdata};
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_buf_r <= 9'h000;
			tx_st_r <= ST_IDLE;
			tx_sh_r <= 12'hfff;
			tx_cnt_r <= 4'h0;
			tx_buf_empty_flag <= 1'b1;
			tx_done_flag <= 1'b0;
			tx_active_r <= 1'b0;
			txd_out <= 1'b1;
			txd_oe <= 1'b0;
			tx_buf_empty_irq <= 1'b0;
			tx_done_irq <= 1'b0;
		end else if (ce) begin
			if (tx_enable_bit) begin
				tx_active_r <= 1'b1;
			end else if (tx_st_r[0] && tx_buf_empty_flag) begin
				tx_active_r <= 1'b0;
			end
			if (data_wr && (tx_enable_bit || tx_active_r)) begin
				tx_buf_r <= {tx_ninth_bit, data_wdata};
				tx_buf_empty_flag <= 1'b0;
			end else if (tx_take) begin
				tx_buf_empty_flag <= 1'b1;
			end
			case (tx_st_r)
				ST_IDLE: begin
					tx_st_r <= ST_IDLE;
				end
				ST_SHIFT: begin
					if (tx_tick) begin
						if (tx_cnt_r == 4'd1) begin
							tx_st_r <= ST_DONE;
						end else begin
							txd_out <= tx_sh_r[0];
							tx_sh_r <= tx_sh_r >> 1;
							tx_cnt_r <= tx_cnt_r - 4'd1;
						end
					end
				end
				ST_DONE: begin
					tx_st_r <= ST_IDLE;
					txd_out <= 1'b1;
					if (tx_buf_empty_flag) begin
						tx_done_flag <= 1'b1;
					end
				end
				default: tx_st_r <= ST_IDLE;
			endcase
			// load overrides the case, so back-to-back frames leave no idle gap
			if (tx_take) begin
				if (parity_enable_bit) begin
					tx_sh_r <= tfr_par;
				end else begin
					tx_sh_r <= tfr_nopar;
				end
				tx_cnt_r <= 4'd1 + tn + {3'b000, parity_enable_bit} + (two_stop ? 4'd2 : 4'd1);
				txd_out <= 1'b0;
				tx_st_r <= ST_SHIFT;
			end
			if (tx_st_r[2] && tx_buf_empty_flag) begin
				tx_done_flag <= 1'b1;
			end else if (tx_done_clr || tx_done_irq_ack) begin
				tx_done_flag <= 1'b0;
			end
			txd_oe <= tx_enable_bit || tx_active_r;
			tx_buf_empty_irq <= tx_buf_empty_irq_en && tx_buf_empty_flag;
			tx_done_irq <= tx_done_irq_en && tx_done_flag;
		end
	end

	// receiver: start detect, majority on samples 8..10, bit shifting
	reg [2:0] rx_st_r;
	reg [3:0] rx_os_r;
	reg [3:0] rx_cnt_r;
	reg [9:0] rx_sh_r;
	reg [2:0] maj_r;
	reg rx_hold_r;
	reg [`SPT_RXF_W-1:0] rx_hold_word_r;
	reg rx_dor_r;
	reg rx_armed_r;
	reg [1:0] rxf_cnt_r;
	reg rxf_wp_r, rxf_rp_r;
	wire [3:0] rn = nbits(char_size_sel);
	wire [3:0] rframe = rn + {3'b000, parity_enable_bit};
	wire rx_in = rx_enable_bit ? rxd_s2_r : 1'b1;
	wire rx_bit_now = sync_mode ? sync_sample : (os_tick && rx_os_r == 4'd10);
	wire maj = (maj_r[0] & maj_r[1]) | (maj_r[1] & maj_r[2]) | (maj_r[0] & maj_r[2]);
	wire rxf_full = (rxf_cnt_r == 2'd2);
	wire rxf_pop = data_rd && rxf_cnt_r != 2'd0;
	wire rxf_push = rx_hold_r && !rxf_full;
	// frame assembled from the shifter once the first stop bit is in
	wire [9:0] rsh = rx_sh_r >> (4'd10 - rframe);
	wire [8:0] rdat = rsh[8:0] & (9'h1ff >> (4'd9 - rn));
	// parity is the last bit shifted in, so it sits at the top
	wire rpar = rx_sh_r[9];
	wire rpe = parity_enable_bit && ((^rdat) ^ parity_odd ^ rpar);
	always @(posedge ref_clk) begin
		if (!rst_n || !rx_enable_bit) begin
			rx_st_r <= ST_IDLE;
			rx_os_r <= 4'h0;
			rx_cnt_r <= 4'h0;
			rx_sh_r <= 10'h000;
			maj_r <= 3'b111;
			rx_hold_r <= 1'b0;
			rx_hold_word_r <= {`SPT_RXF_W{1'b0}};
			rx_dor_r <= 1'b0;
			rx_armed_r <= 1'b0;
		end else if (ce) begin
			// a start needs a high-to-low change; a low stop bit cannot restart
			rx_armed_r <= rx_st_r[0] && (rx_in || rx_armed_r);
			if (rxf_push) begin
				rx_hold_r <= 1'b0;
				rx_dor_r <= 1'b0;
			end
			case (rx_st_r)
				ST_IDLE: begin
					if (!rx_in && rx_armed_r && (sync_mode ? sync_sample : os_tick)) begin
						rx_os_r <= 4'd1;
						rx_cnt_r <= 4'd0;
						rx_st_r <= sync_mode ? ST_SHIFT : ST_DONE;
						if (rxf_full && rx_hold_r) begin
							rx_dor_r <= 1'b1;
						end
					end
				end
				ST_DONE: begin
					// start validation: samples 8, 9, 10 vote
					if (os_tick) begin
						rx_os_r <= rx_os_r + 4'd1;
						if (rx_os_r >= 4'd7 && rx_os_r <= 4'd9) begin
							maj_r <= {maj_r[1:0], rx_in};
						end
						if (rx_os_r == 4'd10) begin
							rx_os_r <= 4'd11;
							rx_st_r <= maj ? ST_IDLE : ST_SHIFT;
						end
					end
				end
				ST_SHIFT: begin
					if (os_tick && !sync_mode) begin
						rx_os_r <= rx_os_r + 4'd1;
					end
					if (rx_bit_now) begin
						if (rx_cnt_r == rframe) begin
							// first stop bit reached; a second one is ignored
							rx_hold_r <= 1'b1;
							rx_hold_word_r <= {!rx_in, rx_dor_r, rpe, rdat};
							rx_st_r <= ST_IDLE;
						end else begin
							rx_sh_r <= {rx_in, rx_sh_r[9:1]};
							rx_cnt_r <= rx_cnt_r + 4'd1;
						end
					end
				end
				default: rx_st_r <= ST_IDLE;
			endcase
		end
	end

	// fifo pointers; disabling the receiver flushes the buffer
	always @(posedge ref_clk) begin
		if (!rst_n || !rx_enable_bit) begin
			rxf_cnt_r <= 2'd0;
			rxf_wp_r <= 1'b0;
			rxf_rp_r <= 1'b0;
		end else if (ce) begin
			if (rxf_push) begin
				rxf_wp_r <= ~rxf_wp_r;
			end
			if (rxf_pop) begin
				rxf_rp_r <= ~rxf_rp_r;
			end
			rxf_cnt_r <= rxf_cnt_r + {1'b0, rxf_push} - {1'b0, rxf_pop};
		end
	end

	wire [`SPT_RXF_W-1:0] rxf_q;
	spt_rx_mem #(.W(`SPT_RXF_W), .AW(`SPT_RXF_AW)) u_rxf (
		.ref_clk(ref_clk),
		.ce(ce),
		.wr_en(rxf_push),
		.wr_addr(rxf_wp_r),
		.wr_data(rx_hold_word_r),
		.rd_addr(rxf_rp_r ^ rxf_pop),
		.rd_data(rxf_q)
	);

	// head of fifo onto the status and data outputs
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_data <= 8'h00;
			rx_ninth_bit <= 1'b0;
			frame_err_flag <= 1'b0;
			overrun_flag <= 1'b0;
			parity_err_flag <= 1'b0;
			rx_avail_flag <= 1'b0;
			rxd_owned <= 1'b0;
		end else if (ce) begin
			rx_data <= rxf_q[7:0];
			rx_ninth_bit <= rxf_q[8];
			parity_err_flag <= rxf_q[9] && rx_avail_flag;
			overrun_flag <= rxf_q[10] && rx_avail_flag;
			frame_err_flag <= rxf_q[11] && rx_avail_flag;
			rx_avail_flag <= (rxf_cnt_r != 2'd0) && rx_enable_bit;
			rxd_owned <= rx_enable_bit;
		end
	end
endmodule // spt_core

/* File: verilog/spt_regs.vh */
// constants for the serial port transmit and receive datapath
`ifndef SPT_REGS_VH
`define SPT_REGS_VH
`define SPT_CSZ_5 3'h0
`define SPT_CSZ_9 3'h7
`define SPT_RXF_W 12
`define SPT_RXF_DEPTH 2
`define SPT_RXF_AW 1
`define SPT_BAUD_DIV_RST 16'h0043
`define SPT_SAMPLES_PER_BIT 16
`define SPT_MID_SAMPLE 8
`endif

/* File: verilog/spt_rx_mem.v */
// two-entry receive buffer storage, registered read data
`timescale 1ns/1ps
module spt_rx_mem #(
	parameter W = 12,
	parameter AW = 1
) (
	input wire ref_clk,
	input wire ce,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [W-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [W-1:0] rd_data
);
	reg [W-1:0] mem [0:(1<<AW)-1];
	// write port and registered read port
	always @(posedge ref_clk) begin
		if (ce) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule // spt_rx_mem

/* File: testbench/spt_peer.sv */
// far-side serial transceiver model
`timescale 1ns/1ps
module spt_peer #(
	parameter BIT = 256
) (
	input wire txd_out,
	output reg rxd_pin,
	output reg ext_serial_clock_pin
);
	// line idles high, clock pin still outside frames
	initial begin
		rxd_pin = 1'b1;
		ext_serial_clock_pin = 1'b0;
	end
	// start, data lsb first, even parity, one stop of chosen level
	task send(input [8:0] d, input integer n, input pe, input stp);
		integer i;
		begin
			for (i = 0; i < n + pe + 2; i = i + 1) begin
				if (i == 0)
					rxd_pin = 1'b0;
				else if (i <= n)
					rxd_pin = d[i-1];
				else if (pe && i == n + 1)
					rxd_pin = ^d;
				else
					rxd_pin = stp;
				ext_serial_clock_pin = 1'b1;
				#(BIT / 2);
				ext_serial_clock_pin = 1'b0;
				#(BIT / 2);
			end
			rxd_pin = 1'b1;
		end
	endtask
	// samples n bits after a start edge, at mid bit
	task grab(input integer n, output [10:0] f);
		integer i;
		begin
			f = 11'h000;
			@(negedge txd_out);
			#(BIT / 2);
			for (i = 0; i < n; i = i + 1) begin
				#(BIT);
				f[i] = txd_out;
			end
		end
	endtask
endmodule // spt_peer

/* File: testbench/spt_core_properties.sv */
// port assertions for the serial port datapath
`timescale 1ns/1ps
module spt_chk #(
	parameter [15:0] BAUD_DIV = 16'h0043
) (
	input wire ref_clk,
	input wire rst_n,
	input wire ce,
	input wire data_wr,
	input wire tx_enable_bit,
	input wire rx_enable_bit,
	input wire tx_buf_empty_irq_en,
	input wire tx_done_irq_en,
	input wire tx_done_clr,
	input wire txd_out,
	input wire txd_oe,
	input wire rxd_owned,
	input wire rx_avail_flag,
	input wire tx_buf_empty_flag,
	input wire tx_done_flag,
	input wire tx_buf_empty_irq,
	input wire tx_done_irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// a taken data write, and the completion flag rising
	sequence s_wr;
		ce && data_wr && tx_enable_bit;
	endsequence
	sequence s_done;
		$rose(tx_done_flag);
	endsequence
	a_wr_clears: assert property (s_wr |=> !tx_buf_empty_flag)
		else $error("empty flag held");
	a_empty_irq: assert property ((tx_buf_empty_irq_en && tx_buf_empty_flag)[*3] |-> tx_buf_empty_irq)
		else $error("empty irq low");
	a_empty_irq_off: assert property (!tx_buf_empty_irq_en[*3] |-> !tx_buf_empty_irq)
		else $error("empty irq high");
	a_done_irq: assert property (s_done and tx_done_irq_en |-> ##[0:1] tx_done_irq)
		else $error("done irq missing");
	a_done_empty: assert property (s_done |-> tx_buf_empty_flag)
		else $error("done with data queued");
	a_done_clear: assert property (tx_done_clr |-> ##[1:2] !tx_done_flag)
		else $error("done not cleared");
	a_tx_defer: assert property ($fell(tx_enable_bit) && !tx_buf_empty_flag |=> txd_oe)
		else $error("early disable");
	a_pin_free: assert property ($fell(txd_oe) |-> !tx_enable_bit && tx_buf_empty_flag)
		else $error("pin freed early");
	a_rx_own: assert property (rx_enable_bit[*2] |-> rxd_owned)
		else $error("rx pin not owned");
	a_rx_flush: assert property (!rx_enable_bit[*3] |-> !rxd_owned && !rx_avail_flag)
		else $error("rx not flushed");
	a_start_owned: assert property ($fell(txd_out) |-> txd_oe)
		else $error("frame on free pin");
endmodule // spt_chk
bind spt_core spt_chk #(.BAUD_DIV(BAUD_DIV)) u_chk (.*);

/* File: testbench/testbench.sv */
// self-checking bench for the serial port datapath
`timescale 1ns/1ps
module testbench;
	reg ref_clk, rst_n, ce, parity_enable_bit, parity_odd, two_stop, sync_mode, clk_pol;
	reg tx_enable_bit, rx_enable_bit, tx_buf_empty_irq_en, tx_done_irq_en, tx_ninth_bit;
	reg data_wr, data_rd, tx_done_clr, tx_done_irq_ack;
	reg [2:0] char_size_sel;
	reg [7:0] data_wdata;
	reg [10:0] fa;
	wire rxd_pin, ext_serial_clock_pin, txd_out, txd_oe, rxd_owned, rx_ninth_bit;
	wire frame_err_flag, overrun_flag, parity_err_flag, rx_avail_flag;
	wire tx_buf_empty_flag, tx_done_flag, tx_buf_empty_irq, tx_done_irq;
	wire [7:0] rx_data;
	integer fail_count, num_checks, cyc;
	// short divider keeps a bit at 32 clocks
	spt_core #(.BAUD_DIV(16'h0001)) u_spt_core (.*);
	spt_peer #(.BIT(256)) peer (.*);
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// hang guard, well above the planned run
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			fail_count = fail_count + 1;
			complete_run;
		end
	end
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", num_checks, fail_count);
			if (fail_count == 0 && num_checks > 0) begin
				$display("== PASSED ==");
			end else begin
				$display("== FAILED ==");
			end
			$finish;
		end
	endtask
	task chk(input [10:0] seen, input [10:0] exp, input [8*8-1:0] nm);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("mismatch %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// inputs always change 1 ns after an edge
	task cy(input integer n);
		begin
			repeat (n) @(posedge ref_clk);
			#1;
		end
	endtask
	task wr(input [7:0] d);
		begin
			data_wr = 1'b1;
			data_wdata = d;
			cy(1);
			data_wr = 1'b0;
			chk(tx_buf_empty_flag, 0, "emptywr");
		end
	endtask
	task rd;
		begin
			data_rd = 1'b1;
			cy(1);
			data_rd = 1'b0;
			cy(3);
		end
	endtask
	// one frame out, then completion flag, irq and its clearing
	task ttx(input [8:0] d, input integer n, input [2:0] cs, input pe, input po, input a);
		reg [10:0] m;
		begin
			char_size_sel = cs;
			{parity_enable_bit, parity_odd, tx_done_irq_en} = {pe, po, a};
			tx_ninth_bit = d[8];
			m = d & ((11'h001 << n) - 1);
			m = m | ((pe & (^m ^ po)) << n) | (11'h001 << (n + pe));
			fork
				wr(d[7:0]);
				peer.grab(n + pe + 1, fa);
			join
			chk(fa, m, "frame");
			repeat (99) if (!tx_done_flag) @(posedge ref_clk);
			cy(2);
			chk(tx_done_flag, 1, "done");
			chk(tx_done_irq, a, "doneirq");
			{tx_done_irq_ack, tx_done_clr} = {a, !a};
			cy(1);
			{tx_done_irq_ack, tx_done_clr} = 2'h0;
			cy(2);
			chk(tx_done_flag, 0, "doneclr");
		end
	endtask
	initial begin
		{rst_n, parity_enable_bit, parity_odd, two_stop, sync_mode, clk_pol} = 6'h00;
		{rx_enable_bit, data_wr, data_rd, tx_done_clr, tx_done_irq_ack} = 5'h00;
		{tx_buf_empty_irq_en, tx_done_irq_en, tx_ninth_bit, ce, tx_enable_bit} = 5'h03;
		{char_size_sel, data_wdata} = 11'h300;
		{fail_count, num_checks, cyc} = 0;
		cy(10);
		rst_n = 1'b1;
		tx_buf_empty_irq_en = 1'b1;
		cy(3);
		chk({tx_buf_empty_flag, txd_out, tx_done_flag}, 3'h6, "idle");
		chk(tx_buf_empty_irq, 1, "emptyirq");
		ttx(9'h0a5, 8, 3'h3, 0, 0, 0);
		ttx(9'h013, 5, 3'h0, 1, 0, 1);
		ttx(9'h16c, 9, 3'h7, 1, 1, 1);
		two_stop = 1'b1;
		ttx(9'h055, 7, 3'h2, 1, 1, 0);
		two_stop = 1'b0;
		$display("test tx frames done");
		// second char queued behind a busy shifter, then disable at once
		{char_size_sel, parity_enable_bit} = 4'h6;
		fork
			peer.grab(9, fa);
			begin
				wr(8'h96);
				repeat (99) if (!tx_buf_empty_flag) @(posedge ref_clk);
				cy(1);
				wr(8'h3c);
				tx_enable_bit = 1'b0;
				cy(2);
				chk(txd_oe, 1, "oehold");
			end
		join
		chk(fa, 11'h196, "first");
		peer.grab(9, fa);
		chk(fa, 11'h13c, "second");
		cy(40);
		chk(txd_oe, 0, "oeoff");
		tx_enable_bit = 1'b1;
		$display("test deferred disable done");
		// two frames fill the buffer, the second with a bad stop bit
		{rx_enable_bit, char_size_sel, parity_enable_bit, parity_odd} = 6'h3e;
		cy(2);
		chk(rxd_owned, 1, "own");
		peer.send(9'h1a5, 9, 1, 1);
		peer.send(9'h05a, 9, 1, 0);
		cy(8);
		chk(rx_avail_flag, 1, "avail");
		chk({parity_err_flag, frame_err_flag, rx_ninth_bit, rx_data}, 11'h1a5, "rx1");
		chk(overrun_flag, 0, "noovr");
		rd;
		chk({parity_err_flag, frame_err_flag, rx_ninth_bit, rx_data}, 11'h25a, "rx2");
		rd;
		chk(rx_avail_flag, 0, "drained");
		// short char with wrong parity, then flush by disabling
		// this one goes on the external clock pin
		{char_size_sel, parity_odd, sync_mode} = 5'h03;
		peer.send(9'h01f, 5, 1, 1);
		cy(8);
		chk({parity_err_flag, frame_err_flag, rx_ninth_bit, rx_data}, 11'h41f, "rx3");
		sync_mode = 1'b0;
		rx_enable_bit = 1'b0;
		cy(4);
		chk({rx_avail_flag, rxd_owned}, 2'h0, "flush");
		$display("test receive done");
		complete_run;
	end
endmodule // testbench
